// *** watchdog_window_pkg.sv ***
/*
 Constants, field layouts and shared types of the watchdog window
 configuration block. Assumes a 10 MHz APB clock and a 1 kHz watchdog tick.
*/
package watchdog_window_pkg;

  localparam int unsigned PCLK_PERIOD_NS = 100;
  localparam int unsigned WD_TICK_PERIOD_NS = 1_000_000;
  localparam int unsigned TICK_DIV_CYCLES = WD_TICK_PERIOD_NS / PCLK_PERIOD_NS;

  // Register indices; the byte address is four times the index.
  localparam logic [3:0] IDX_CTRL = 4'h0;
  localparam logic [3:0] IDX_WINDOW = 4'h1;
  localparam logic [3:0] IDX_STATUS = 4'h2;
  localparam logic [3:0] IDX_PROTECT = 4'h3;

  localparam int PERIOD_LSB = 2;
  localparam int PERIOD_MSB = 5;
  localparam int ENABLE_BIT = 1;
  localparam int CHANGE_BIT = 0;
  localparam int SYNC_PENDING_BIT = 0;

  localparam logic [3:0] CODE_MAX = 4'ha;
  localparam logic [13:0] BASE_CYCLES = 14'h0008;
  localparam logic [7:0] PROTECT_KEY = 8'h5a; // Arbitrary signature value.
  localparam logic [2:0] PROTECT_OPEN_CYCLES = 3'h4;
  localparam logic [1:0] FUSE_LOAD_DELAY = 2'h2;
  localparam logic CHANGE_RESET = 1'b0;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  typedef struct packed {
    logic [3:0] closed_window_period;
    logic [3:0] open_period;
    logic en;
    logic lock;
  } fuse_t;

  typedef struct packed {
    logic [3:0] open_period;
    logic en;
    logic [3:0] closed_window_period;
    logic wen;
  } wd_cfg_t;

  typedef enum logic {
    PH_OPEN = 1'b0,
    PH_CLOSED = 1'b1
  } phase_t;

  // Cycles of the 1 kHz tick for a period code; zero marks a reserved code.
  function automatic logic [13:0] period_cycles(input logic [3:0] code);
    if (code > CODE_MAX) begin
      period_cycles = 14'h0000;
    end else begin
      period_cycles = BASE_CYCLES << code;
    end
  endfunction

endpackage

// *** watchdog_window_config_status.sv ***
/*
 Watchdog window configuration and status with an APB slave, a 1 kHz
 tick divider and the watchdog counter. Assumes fuse levels come from
 outside the clock domain and the restart pulse from logic on pclk.
*/
// Overview of operation
// - Closed window length is window_control bits 5:2.
// - Codes 0..10 give 8 to 8K ticks.
// - Reserved closed codes give no closed timeout.
// - Closed field loads from window period fuses.
// - Normal mode ignores the closed field.
// - Field changes only with change-allow set.
// - Bit 1 enables window mode, change-allow gated.
// - Writes lacking change-allow bit are discarded.
// - Writes need the timed protection sequence first.
// - Window change-allow stays writable under lock fuse.
// - Busy flag set while settings cross over.
// - Busy flag clears itself after transfer.
// - Transfer and busy only while watchdog enabled.
// - Status bits 7:1 read zero.
// - Restart in closed window requests reset.
// - Lock fuse freezes closed field and whole control register.
// - Counter runs from a 1 kHz tick.
`timescale 1ns/10ps
module watchdog_window_config_status #(
  parameter int unsigned TICK_DIV = watchdog_window_pkg::TICK_DIV_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire watchdog_window_pkg::fuse_t fuses,
  input wire logic restart,
  output logic system_reset_req,
  output logic sync_pending_flag,
  output watchdog_window_pkg::wd_cfg_t wd_cfg
);
  import watchdog_window_pkg::*;

  typedef struct packed {
    fuse_t fuse_s1;
    fuse_t fuse_s2;
    logic [1:0] load_cnt;
    logic loaded;
    logic [3:0] open_period;
    logic wd_enable;
    logic control_change_allow;
    logic [3:0] closed_window_period;
    logic window_enable;
    logic window_change_allow;
    logic lock;
    logic [2:0] prot_cnt;
    wd_cfg_t wd;
    logic sync_pending;
    logic [13:0] div_cnt;
    logic [13:0] wd_cnt;
    phase_t phase;
    logic rst_req;
    logic [31:0] rdata;
  } state_t;

  state_t st_ff;
  state_t nxt_st;
  logic [3:0] idx;
  logic mapped;
  logic wr;
  logic tick;
  logic prot_open;
  logic ctrl_acc;
  logic win_acc;
  logic sync_start;
  logic [13:0] closed_len;
  logic [13:0] open_len;
  logic closed_used;

  assign idx = paddr[5:2];
  assign mapped = (paddr[1:0] == 2'b00) && (paddr[7:6] == 2'b00) &&
                  (idx <= IDX_PROTECT);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign wr = psel && penable && pwrite && mapped;
  assign tick = st_ff.div_cnt == 14'(TICK_DIV - 1);
  assign prot_open = st_ff.prot_cnt != 3'h0;
  // Control writes need the key window and their own change bit.
  assign ctrl_acc = wr && idx == IDX_CTRL && prot_open &&
                    pwdata[CHANGE_BIT] && !st_ff.lock;
  assign win_acc = wr && idx == IDX_WINDOW && prot_open &&
                   pwdata[CHANGE_BIT];
  // A disable write still has to cross over, so the old enable counts too.
  assign sync_start = (ctrl_acc || win_acc) &&
                      (st_ff.wd_enable || (ctrl_acc && pwdata[ENABLE_BIT]));
  assign closed_len = period_cycles(st_ff.wd.closed_window_period);
  assign open_len = period_cycles(st_ff.wd.open_period);
  assign closed_used = st_ff.wd.wen && closed_len != 14'h0000;

  assign prdata = st_ff.rdata;
  assign system_reset_req = st_ff.rst_req;
  assign sync_pending_flag = st_ff.sync_pending;
  assign wd_cfg = st_ff.wd;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.fuse_s1 = fuses;
    nxt_st.fuse_s2 = st_ff.fuse_s1;
    nxt_st.rst_req = 1'b0;
    // Fuse levels are taken only once the synchroniser has settled.
    if (!st_ff.loaded) begin
      if (st_ff.load_cnt == FUSE_LOAD_DELAY) begin
        nxt_st.loaded = 1'b1;
        nxt_st.closed_window_period =
          st_ff.fuse_s2.closed_window_period;
        nxt_st.open_period = st_ff.fuse_s2.open_period;
        nxt_st.wd_enable = st_ff.fuse_s2.en;
        nxt_st.lock = st_ff.fuse_s2.lock;
        nxt_st.wd.closed_window_period =
          st_ff.fuse_s2.closed_window_period;
        nxt_st.wd.open_period = st_ff.fuse_s2.open_period;
        nxt_st.wd.en = st_ff.fuse_s2.en;
      end else begin
        nxt_st.load_cnt = st_ff.load_cnt + 2'h1;
      end
    end
    if (prot_open) begin
      nxt_st.prot_cnt = st_ff.prot_cnt - 3'h1;
    end
    if (wr && idx == IDX_PROTECT && pwdata[7:0] == PROTECT_KEY) begin
      nxt_st.prot_cnt = PROTECT_OPEN_CYCLES;
    end
    if (ctrl_acc) begin
      nxt_st.open_period = pwdata[PERIOD_MSB:PERIOD_LSB];
      nxt_st.wd_enable = pwdata[ENABLE_BIT];
      nxt_st.control_change_allow = pwdata[CHANGE_BIT];
    end
    if (win_acc) begin
      if (!st_ff.lock) begin
        nxt_st.closed_window_period =
          pwdata[PERIOD_MSB:PERIOD_LSB];
      end
      nxt_st.window_enable = pwdata[ENABLE_BIT];
      nxt_st.window_change_allow = pwdata[CHANGE_BIT];
    end
    // A new write in a tick cycle keeps the flag up for another tick.
    if (sync_start) begin
      nxt_st.sync_pending = 1'b1;
    end else if (tick && st_ff.sync_pending) begin
      nxt_st.sync_pending = 1'b0;
      nxt_st.wd.open_period = st_ff.open_period;
      nxt_st.wd.en = st_ff.wd_enable;
      nxt_st.wd.closed_window_period = st_ff.closed_window_period;
      nxt_st.wd.wen = st_ff.window_enable;
    end
    if (tick) begin
      nxt_st.div_cnt = 14'h0000;
    end else begin
      nxt_st.div_cnt = st_ff.div_cnt + 14'h0001;
    end
    if (!st_ff.wd.en) begin
      nxt_st.wd_cnt = 14'h0000;
      nxt_st.phase = closed_used ? PH_CLOSED : PH_OPEN;
    end else if (restart) begin
      nxt_st.wd_cnt = 14'h0000;
      nxt_st.phase = closed_used ? PH_CLOSED : PH_OPEN;
      if (st_ff.phase == PH_CLOSED) begin
        nxt_st.rst_req = 1'b1;
      end
    end else if (tick) begin
      nxt_st.wd_cnt = st_ff.wd_cnt + 14'h0001;
      if (st_ff.phase == PH_CLOSED) begin
        if (!closed_used || st_ff.wd_cnt + 14'h0001 >= closed_len) begin
          nxt_st.phase = PH_OPEN;
          nxt_st.wd_cnt = 14'h0000;
        end
      end else if (open_len != 14'h0000 &&
                   st_ff.wd_cnt + 14'h0001 >= open_len) begin
        nxt_st.rst_req = 1'b1;
        nxt_st.wd_cnt = 14'h0000;
        nxt_st.phase = closed_used ? PH_CLOSED : PH_OPEN;
      end
    end
    // A reserved code copied in mid-window ends the closed phase at once.
    if (st_ff.wd.en && !restart && st_ff.phase == PH_CLOSED &&
        !closed_used) begin
      nxt_st.phase = PH_OPEN;
      nxt_st.wd_cnt = 14'h0000;
    end
    if (psel && !penable) begin
      unique case (idx)
        IDX_CTRL: nxt_st.rdata = {26'h000_0000, st_ff.open_period,
                                  st_ff.wd_enable,
                                  st_ff.control_change_allow};
        IDX_WINDOW: nxt_st.rdata = {26'h000_0000,
                                    st_ff.closed_window_period,
                                    st_ff.window_enable,
                                    st_ff.window_change_allow};
        IDX_STATUS: nxt_st.rdata = {24'h00_0000,
                                    STATUS_RESET[7:1],
                                    st_ff.sync_pending};
        default: nxt_st.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= '0;
      st_ff.control_change_allow <= CHANGE_RESET;
      st_ff.window_change_allow <= CHANGE_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  property p_discard_no_change;
    @(posedge pclk) disable iff (!presetn)
      (wr && idx == IDX_WINDOW && !pwdata[CHANGE_BIT]) |=>
        $stable(st_ff.window_enable) && $stable(st_ff.window_change_allow);
  endproperty
  a_discard_no_change: assert property (p_discard_no_change)
    else $error("Window write without change bit was taken.");

  property p_protect_needed;
    @(posedge pclk) disable iff (!presetn)
      (wr && idx == IDX_WINDOW && !prot_open && st_ff.loaded) |=>
        $stable(st_ff.closed_window_period) && $stable(st_ff.window_enable);
  endproperty
  a_protect_needed: assert property (p_protect_needed)
    else $error("Window write outside protection window was taken.");

  property p_lock_field;
    @(posedge pclk) disable iff (!presetn)
      (st_ff.lock && st_ff.loaded) |=> $stable(st_ff.closed_window_period);
  endproperty
  a_lock_field: assert property (p_lock_field)
    else $error("Closed window field changed under lock.");

  property p_busy_set;
    @(posedge pclk) disable iff (!presetn)
      (win_acc && st_ff.wd_enable) |=> sync_pending_flag;
  endproperty
  a_busy_set: assert property (p_busy_set)
    else $error("Busy flag not raised after accepted write.");

  property p_busy_needs_enable;
    @(posedge pclk) disable iff (!presetn)
      (!sync_pending_flag && !st_ff.wd_enable && !ctrl_acc) |=>
        !sync_pending_flag;
  endproperty
  a_busy_needs_enable: assert property (p_busy_needs_enable)
    else $error("Busy flag raised while watchdog disabled.");

  property p_busy_clear;
    @(posedge pclk) disable iff (!presetn)
      (sync_pending_flag && tick && !sync_start) |=>
        !sync_pending_flag && wd_cfg.closed_window_period ==
          $past(st_ff.closed_window_period);
  endproperty
  a_busy_clear: assert property (p_busy_clear)
    else $error("Busy flag did not clear with copy update.");

  property p_reserved_closed;
    @(posedge pclk) disable iff (!presetn)
      (st_ff.phase == PH_CLOSED && wd_cfg.en && tick) |-> closed_used;
  endproperty
  a_reserved_closed: assert property (p_reserved_closed)
    else $error("Closed window counted with reserved code.");

  property p_early_restart;
    @(posedge pclk) disable iff (!presetn)
      (restart && wd_cfg.en && st_ff.phase == PH_CLOSED) |=>
        system_reset_req ##1 !system_reset_req;
  endproperty
  a_early_restart: assert property (p_early_restart)
    else $error("Restart in closed window gave no reset.");

  property p_status_zero;
    @(posedge pclk) disable iff (!presetn)
      (psel && !penable && idx == IDX_STATUS) |=> prdata[31:1] == 31'h0;
  endproperty
  a_status_zero: assert property (p_status_zero)
    else $error("Status upper bits not zero.");

  property p_closed_bound;
    @(posedge pclk) disable iff (!presetn)
      (st_ff.phase == PH_CLOSED && closed_used) |-> st_ff.wd_cnt < closed_len;
  endproperty
  a_closed_bound: assert property (p_closed_bound)
    else $error("Closed window count passed decoded length.");

  property p_tick_step;
    @(posedge pclk) disable iff (!presetn)
      !tick |=> st_ff.div_cnt == $past(st_ff.div_cnt) + 14'h0001;
  endproperty
  a_tick_step: assert property (p_tick_step)
    else $error("Tick divider skipped a count.");

  property p_busy_hold;
    @(posedge pclk) disable iff (!presetn)
      (sync_pending_flag && !tick) |=> sync_pending_flag;
  endproperty
  a_busy_hold: assert property (p_busy_hold)
    else $error("Busy flag dropped between ticks.");

  property p_copy_still;
    @(posedge pclk) disable iff (!presetn)
      (st_ff.loaded && !(sync_pending_flag && tick && !sync_start)) |=>
        $stable(wd_cfg);
  endproperty
  a_copy_still: assert property (p_copy_still)
    else $error("Watchdog copy changed without a finished transfer.");

  property p_ctrl_discard;
    @(posedge pclk) disable iff (!presetn)
      (st_ff.loaded && wr && idx == IDX_CTRL && !pwdata[CHANGE_BIT]) |=>
        $stable(st_ff.wd_enable) && $stable(st_ff.open_period);
  endproperty
  a_ctrl_discard: assert property (p_ctrl_discard)
    else $error("Control write without change bit was taken.");

  property p_field_change;
    @(posedge pclk) disable iff (!presetn)
      (st_ff.loaded && !win_acc) |=> $stable(st_ff.closed_window_period);
  endproperty
  a_field_change: assert property (p_field_change)
    else $error("Closed field changed without an accepted write.");

  property p_open_no_reset;
    @(posedge pclk) disable iff (!presetn)
      (restart && wd_cfg.en && st_ff.phase == PH_OPEN) |=> !system_reset_req;
  endproperty
  a_open_no_reset: assert property (p_open_no_reset)
    else $error("Restart in open window gave a reset.");

  property p_closed_no_timeout;
    @(posedge pclk) disable iff (!presetn)
      (st_ff.phase == PH_CLOSED && wd_cfg.en && !restart) |=>
        !system_reset_req;
  endproperty
  a_closed_no_timeout: assert property (p_closed_no_timeout)
    else $error("Timeout raised during the closed window.");

endmodule // watchdog_window_config_status

// *** tb_top.sv ***
/*
 Self-checking bench for the watchdog window configuration block.
 Assumes the design package and module are compiled ahead of this file.
*/
`timescale 1ns/10ps
`define CHK(n, e, g) begin \
  num_checks++; \
  if ((g) !== (e)) begin \
    failures++; \
    $display("unexpected %s expected %h seen %h", n, e, g); \
  end \
end
module tb_top;
  import watchdog_window_pkg::*;
  // A short tick keeps window and sync waits to a few dozen cycles.
  localparam int unsigned TDIV = 8;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  fuse_t fuses = '{closed_window_period: 4'h5, open_period: 4'hf,
                   en: 1'b1, lock: 1'b0};
  logic restart = 1'b0;
  logic system_reset_req;
  logic sync_pending_flag;
  wd_cfg_t wd_cfg;
  int failures = 0;
  int num_checks = 0;
  int cycles = 0;
  int hits;
  logic [31:0] rd;
  logic err;
  logic [7:0] w0;

  always #50 pclk = ~pclk;

  watchdog_window_config_status #(
    .TICK_DIV(TDIV)
  ) watchdog_window_config_status_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fuses(fuses), .restart(restart),
    .system_reset_req(system_reset_req),
    .sync_pending_flag(sync_pending_flag), .wd_cfg(wd_cfg));

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      give_verdict();
    end
  end

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // The key opens only a few cycles, so the write follows it directly.
  task automatic prot_write(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, 8'h0c, {24'h00_0000, PROTECT_KEY});
    apb(1'b1, a, {24'h00_0000, d});
    #1;
  endtask

  task automatic wait_sync;
    int n;
    n = 0;
    while (sync_pending_flag !== 1'b0 && n < 4 * TDIV) begin
      @(posedge pclk);
      #1;
      n++;
    end
    `CHK("busy cleared", 1'b0, sync_pending_flag)
  endtask

  // Returns at the edge that takes the second restart, so a reset
  // pulse from it falls inside the following count.
  task automatic restart_twice;
    @(posedge pclk);
    restart <= 1'b1;
    @(posedge pclk);
    restart <= 1'b0;
    repeat (3) @(posedge pclk);
    restart <= 1'b1;
    @(posedge pclk);
    restart <= 1'b0;
  endtask

  task automatic count_resets(input int span);
    hits = 0;
    repeat (span) begin
      #1;
      if (system_reset_req === 1'b1) hits++;
      @(posedge pclk);
    end
  endtask

  task automatic t_reset;
    apb(1'b0, 8'h04, 32'h0000_0000);
    w0 = rd[7:0];
    `CHK("ready", 1'b1, pready)
    `CHK("closed field", 4'h5, rd[5:2])
    `CHK("change bit", 1'b0, rd[0])
    apb(1'b0, 8'h08, 32'h0000_0000);
    `CHK("status", 32'h0000_0000, rd)
    $display("test reset done");
  endtask

  task automatic t_discard;
    prot_write(8'h04, 8'h0e);
    apb(1'b0, 8'h04, 32'h0000_0000);
    `CHK("no change bit", w0, rd[7:0])
    apb(1'b1, 8'h04, 32'h0000_000f);
    apb(1'b0, 8'h04, 32'h0000_0000);
    `CHK("no key", w0, rd[7:0])
    $display("test discard done");
  endtask

  task automatic t_accept;
    prot_write(8'h04, 8'h03);
    `CHK("busy set", 1'b1, sync_pending_flag)
    apb(1'b0, 8'h04, 32'h0000_0000);
    `CHK("window reg", 8'h03, rd[7:0])
    wait_sync();
    `CHK("copy closed", 4'h0, wd_cfg.closed_window_period)
    `CHK("copy wen", 1'b1, wd_cfg.wen)
    $display("test accept done");
  endtask

  task automatic t_windows;
    // The second restart lands well inside an 8-tick closed window.
    restart_twice();
    count_resets(4);
    `CHK("early restart", 1, hits)
    prot_write(8'h04, 8'h2f);
    wait_sync();
    restart_twice();
    count_resets(100);
    `CHK("reserved code", 0, hits)
    prot_write(8'h04, 8'h01);
    wait_sync();
    `CHK("window off", 1'b0, wd_cfg.wen)
    restart_twice();
    count_resets(100);
    `CHK("normal mode", 0, hits)
    $display("test windows done");
  endtask

  task automatic t_unmapped;
    apb(1'b0, 8'h10, 32'h0000_0000);
    `CHK("slave error", 1'b1, err)
    `CHK("unmapped data", 32'h0000_0000, rd)
    apb(1'b1, 8'h08, 32'h0000_00ff);
    apb(1'b0, 8'h08, 32'h0000_0000);
    `CHK("status write", 32'h0000_0000, rd)
    $display("test unmapped done");
  endtask

  task automatic t_idle_sync;
    // A short open period first, so the plain timeout is exercised.
    prot_write(8'h00, 8'h03);
    wait_sync();
    restart_twice();
    count_resets(70);
    `CHK("open timeout", 1, hits)
    prot_write(8'h00, 8'h3d);
    wait_sync();
    `CHK("copy en", 1'b0, wd_cfg.en)
    `CHK("copy open", 4'hf, wd_cfg.open_period)
    prot_write(8'h04, 8'h03);
    `CHK("busy idle", 1'b0, sync_pending_flag)
    repeat (2 * TDIV) @(posedge pclk);
    `CHK("copy held", 1'b0, wd_cfg.wen)
    $display("test idle sync done");
  endtask

  task automatic t_lock;
    presetn <= 1'b0;
    fuses.lock <= 1'b1;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    prot_write(8'h04, 8'h0b);
    apb(1'b0, 8'h04, 32'h0000_0000);
    `CHK("locked field", 4'h5, rd[5:2])
    `CHK("locked bits", 2'b11, rd[1:0])
    $display("test lock done");
  endtask

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    t_reset();
    t_discard();
    t_accept();
    t_windows();
    t_unmapped();
    t_idle_sync();
    t_lock();
    give_verdict();
  end
endmodule // tb_top
